// ===== core/iev_consts.svh
// register offsets, field positions and reset values of the event control logic
`ifndef IEV_CONSTS_SVH
`define IEV_CONSTS_SVH

// ---------------------------------------------------------------
// register byte addresses (word aligned)
// ---------------------------------------------------------------
`define IEV_ADDR_CTRL    4'h0
`define IEV_ADDR_STAT1   4'h4
`define IEV_ADDR_STAT2   4'h8
`define IEV_ADDR_DATA    4'hc

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define IEV_CR_IRQEN     0
`define IEV_CR_STOP      1
`define IEV_CR_ACK       2
`define IEV_CR_START     3
`define IEV_CR_GCEN      4
`define IEV_CR_ENABLE    5
`define IEV_CR_RESET     8'h00
`define IEV_CR_WMASK     8'h3f

// ---------------------------------------------------------------
// status register 1 fields
// ---------------------------------------------------------------
`define IEV_S1_START     0
`define IEV_S1_MASTER    1
`define IEV_S1_ADDR      2
`define IEV_S1_BYTE      3
`define IEV_S1_BUSY      4
`define IEV_S1_DIR       5
`define IEV_S1_HEADER    6
`define IEV_S1_EVENT     7

// ---------------------------------------------------------------
// status register 2 fields
// ---------------------------------------------------------------
`define IEV_S2_GCALL     0
`define IEV_S2_BUS_ERROR_FLAG      1
`define IEV_S2_ARBITRATION_LOST_FLAG      2
`define IEV_S2_STOP      3
`define IEV_S2_AF        4

`define IEV_DATA_RESET   8'h00
`define IEV_DATA_ONES    8'hff

`endif

// ===== core/iev_pkg.sv
// types shared by the event control logic
package iev_pkg;
	typedef enum logic [2:0] {
		IEV_IDLE = 3'b001,
		IEV_READ = 3'b010,
		IEV_WAIT = 3'b100
	} iev_bus_t;
endpackage

// ===== core/iev_event_ctrl.sv
// event sequencing, flags, interrupt and control of a two-wire bus interface
// Operation
// - address match sets event and match flag
// - received byte: cleared by status1 then data read
// - sent byte: cleared by status1 then data write
// - slave nack: failure flag, byte flag release paths
// - slave stop sets stop flag, status2 read clears
// - start sent: cleared by status1 then data write
// - address sent: cleared by status1 then control write
// - header sent flag; cleared when disabled
// - header flag cleared by second address write
// - wait mode: runs on, interrupts wake core
// - halt freezes registers, no acknowledge, no wake
// - one interrupt, gated by enable and mask
// - control bits seven and six read zero
// - disable clears all bits but stop bit
// - enable hands pins; first write sets enable and stop only
// - general call acknowledges 00h, receive only
// - start bit requests start, hardware clears
// - acknowledge enable; cleared when disabled
// - master stop bit cleared when stop sent
// - slave stop releases lines after byte done
// - clock held low while hold flags pending
// - event flag set by every flag-setting event except bus start (busy), including start sent but not stop sent; cleared accordingly
// - busy set on start, cleared on stop/error
`timescale 1ns/10ps
`include "iev_consts.svh"

module iev_event_ctrl
	import iev_pkg::*;
#(
	parameter int ADDR_W = 4
) (
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	// core power and interrupt
	input  wire logic              haltMode,
	input  wire logic              globalMask,
	output logic                   irqReq,
	output logic                   wakeReq,
	// events from the serial engine (async to sys_clk)
	input  wire logic              evAddrMatch,
	input  wire logic              evGenCall,
	input  wire logic              evByteRx,
	input  wire logic              evByteTx,
	input  wire logic              evNack,
	input  wire logic              evStart,
	input  wire logic              evStop,
	input  wire logic              evStartSent,
	input  wire logic              evStopSent,
	input  wire logic              evHeaderSent,
	input  wire logic              evAddrSent,
	input  wire logic              evArbLost,
	input  wire logic              evBusError,
	input  wire logic              slaveActive,
	// control to the serial engine
	output logic                   pinsOwned,
	output logic                   ackOut,
	output logic                   startReq,
	output logic                   stopReq,
	output logic                   releaseLines,
	output logic                   sclHoldLow,
	output logic                   genCallRecvOnly,
	output logic [7:0]             txData,
	input  wire logic [7:0]        rxData
);

	// ---------------------------------------------------------------
	// input synchronisers and edge detect
	// ---------------------------------------------------------------
	localparam int NEV = 13;
	logic [NEV-1:0] evRaw, evMeta_r, evSync_r, evOld_r, evPulse;
	logic [7:0]     rxMeta_r, rxSync_r;
	assign evRaw = {evBusError, evArbLost, evAddrSent, evHeaderSent,
		evStopSent, evStartSent, evStop, evStart, evNack, evByteTx,
		evByteRx, evGenCall, evAddrMatch};

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			evMeta_r <= '0;
			evSync_r <= '0;
			evOld_r  <= '0;
			rxMeta_r <= 8'h00;
			rxSync_r <= 8'h00;
		end else begin
			evMeta_r <= evRaw;
			evSync_r <= evMeta_r;
			evOld_r  <= evSync_r;
			// rx byte settles before its event edge, two stages suffice
			rxMeta_r <= rxData;
			rxSync_r <= rxMeta_r;
		end
	end
	// every event input is a level that toggles high; rising edge = event
	assign evPulse = evSync_r & ~evOld_r;

	logic [1:0] slvMeta_r;
	logic       slvAct;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			slvMeta_r <= 2'b00;
		else
			slvMeta_r <= {slvMeta_r[0], slaveActive};
	end
	assign slvAct = slvMeta_r[1];

	logic       active;
	logic       pAddr, pGc, pRx, pTx, pNack, pStart, pStop, pStSent;
	logic       pSpSent, pHdr, pASent, pArlo, pBerr;
	always_comb begin
		{pBerr, pArlo, pASent, pHdr, pSpSent, pStSent, pStop, pStart,
			pNack, pTx, pRx, pGc, pAddr} = evPulse;
	end

	// ---------------------------------------------------------------
	// avalon slave: one wait cycle on read, zero on write
	// ---------------------------------------------------------------
	iev_bus_t busSt_r;
	logic     rdAcc, wrAcc;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			busSt_r <= IEV_IDLE;
		else begin
			unique case (busSt_r)
				IEV_IDLE: busSt_r <= read ? IEV_READ : IEV_IDLE;
				IEV_READ: busSt_r <= IEV_WAIT;
				IEV_WAIT: busSt_r <= read ? IEV_READ : IEV_IDLE;
			endcase
		end
	end
	// read data is captured in IDLE or WAIT, the cycle before READ, and held; master samples in READ
	// a read held through the idle slot costs one extra wait
	assign waitrequest = read && busSt_r != IEV_READ;
	assign rdAcc = read && busSt_r == IEV_READ;
	assign wrAcc = write;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [3:0] off);
		hit = a == ADDR_W'(off);
	endfunction

	logic rdS1, rdS2, rdDr, wrCr, wrDr;
	assign rdS1 = rdAcc && hit(address, `IEV_ADDR_STAT1);
	assign rdS2 = rdAcc && hit(address, `IEV_ADDR_STAT2);
	assign rdDr = rdAcc && hit(address, `IEV_ADDR_DATA);
	assign wrCr = wrAcc && hit(address, `IEV_ADDR_CTRL);
	assign wrDr = wrAcc && hit(address, `IEV_ADDR_DATA);

	// ---------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------
	logic [7:0] ctrl_r;
	logic       enable;
	logic       master_r;
	assign enable = ctrl_r[`IEV_CR_ENABLE];
	// halt freezes the control, flag and data registers; serial events in halt are dropped
	assign active = !haltMode;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			ctrl_r <= `IEV_CR_RESET;
		else if (active) begin
			if (wrCr && !enable)
				// first enabling write sets only the enable and stop bits
				ctrl_r <= {2'b00, writedata[`IEV_CR_ENABLE], 3'b000,
					writedata[`IEV_CR_STOP] | ctrl_r[`IEV_CR_STOP],
					1'b0} & {6'h3f, 1'b1 & writedata[`IEV_CR_ENABLE]
					| 1'b1, 1'b0};
			else if (wrCr)
				ctrl_r <= writedata[7:0] & `IEV_CR_WMASK;
			else if (!enable)
				ctrl_r <= ctrl_r & (8'h01 << `IEV_CR_STOP);
			else begin
				if (pStSent)
					ctrl_r[`IEV_CR_START] <= 1'b0;
				if (pSpSent && master_r)
					ctrl_r[`IEV_CR_STOP] <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// status flags
	// ---------------------------------------------------------------
	logic dir_r, busy_r, byteDone_r, addrMatch_r, startSent_r;
	logic header_r, addrEv_r, ackFail_r, stopSeen_r, arbitration_lost_flag_r, bus_error_flag_r;
	logic gcSeen_r, s1Read_r, event_r, byteRelease_r, stopMute_r;
	logic [7:0] data_r;

	// status1 read arms the second step of a clearing sequence
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			s1Read_r <= 1'b0;
		else if (active) begin
			if (!enable || wrDr || rdDr || wrCr)
				s1Read_r <= rdS1;
			else if (rdS1)
				s1Read_r <= 1'b1;
		end
	end

	logic seqRdDr, seqWrDr, seqWrCr;
	assign seqRdDr = s1Read_r && rdDr;
	assign seqWrDr = s1Read_r && wrDr;
	assign seqWrCr = s1Read_r && wrCr;

	// sets win over clears in each flag
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			addrMatch_r <= 1'b0;
			byteDone_r  <= 1'b0;
			dir_r       <= 1'b0;
			ackFail_r   <= 1'b0;
			stopSeen_r  <= 1'b0;
			startSent_r <= 1'b0;
			addrEv_r    <= 1'b0;
			header_r    <= 1'b0;
			arbitration_lost_flag_r      <= 1'b0;
			bus_error_flag_r      <= 1'b0;
			gcSeen_r    <= 1'b0;
			master_r    <= 1'b0;
		end else if (active) begin
			if (!enable) begin
				{addrMatch_r, byteDone_r, dir_r, ackFail_r} <= 4'h0;
				{stopSeen_r, startSent_r, addrEv_r, header_r} <= 4'h0;
				{arbitration_lost_flag_r, bus_error_flag_r, gcSeen_r, master_r} <= 4'h0;
			end else begin
				if (pAddr || (pGc && ctrl_r[`IEV_CR_GCEN]))
					addrMatch_r <= 1'b1;
				else if (rdS1)
					addrMatch_r <= 1'b0;
				if (pGc && ctrl_r[`IEV_CR_GCEN])
					gcSeen_r <= 1'b1;
				else if (pStop)
					gcSeen_r <= 1'b0;
				if (pRx || pTx) begin
					byteDone_r <= 1'b1;
					dir_r      <= pTx;
				end else if ((!dir_r && seqRdDr) ||
					(dir_r && seqWrDr) ||
					(ackFail_r && wrDr &&
					writedata[7:0] == `IEV_DATA_ONES) ||
					byteRelease_r) begin
					byteDone_r <= 1'b0;
					dir_r      <= 1'b0;
				end else if (pStop || pArlo)
					dir_r <= 1'b0;
				if (pNack)
					ackFail_r <= 1'b1;
				else if (rdS1 || rdS2)
					ackFail_r <= 1'b0;
				if (pStop && slvAct && !ctrl_r[`IEV_CR_STOP] && !stopMute_r)
					stopSeen_r <= 1'b1;
				else if (rdS2)
					stopSeen_r <= 1'b0;
				if (pStSent)
					startSent_r <= 1'b1;
				else if (seqWrDr)
					startSent_r <= 1'b0;
				if (pASent)
					addrEv_r <= 1'b1;
				else if (seqWrCr)
					addrEv_r <= 1'b0;
				if (pHdr)
					header_r <= 1'b1;
				else if (seqWrDr)
					header_r <= 1'b0;
				if (pArlo)
					arbitration_lost_flag_r <= 1'b1;
				else if (rdS2)
					arbitration_lost_flag_r <= 1'b0;
				if (pBerr)
					bus_error_flag_r <= 1'b1;
				else if (rdS2)
					bus_error_flag_r <= 1'b0;
				if (pStSent)
					master_r <= 1'b1;
				else if (pStop || pArlo)
					master_r <= 1'b0;
			end
		end
	end

	// busy is held clear and not updated while disabled
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			busy_r <= 1'b0;
		else if (active) begin
			if (!enable)
				busy_r <= 1'b0;
			else if (pStart)
				busy_r <= 1'b1;
			else if (pStop || pBerr)
				busy_r <= 1'b0;
		end
	end

	// stop set then cleared while byte done releases the byte flag
	logic stopPrev_r;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			stopPrev_r    <= 1'b0;
			byteRelease_r <= 1'b0;
		end else if (active) begin
			stopPrev_r    <= ctrl_r[`IEV_CR_STOP];
			byteRelease_r <= stopPrev_r && !ctrl_r[`IEV_CR_STOP] &&
				byteDone_r && !master_r;
		end
	end

	// the stop that ends a released transfer is not reported
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			stopMute_r <= 1'b0;
		else if (active) begin
			if (!enable || pStop || pStart)
				stopMute_r <= 1'b0;
			else if (byteRelease_r)
				stopMute_r <= 1'b1;
		end
	end

	// event flag follows its sources, so it drops only after all clear
	logic anySrc;
	assign anySrc = addrMatch_r | byteDone_r | ackFail_r | stopSeen_r |
		startSent_r | addrEv_r | header_r | arbitration_lost_flag_r | bus_error_flag_r;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			event_r <= 1'b0;
		else if (active)
			event_r <= enable && anySrc;
	end

	// ---------------------------------------------------------------
	// data register and read mux
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			data_r <= `IEV_DATA_RESET;
		else if (active) begin
			if (wrDr)
				data_r <= writedata[7:0];
			else if (pRx)
				data_r <= rxSync_r;
		end
	end

	logic [7:0] stat1, stat2;
	assign stat1 = {event_r, header_r, dir_r, busy_r, byteDone_r,
		addrMatch_r, master_r, startSent_r};
	assign stat2 = {3'b000, ackFail_r, stopSeen_r, arbitration_lost_flag_r, bus_error_flag_r,
		gcSeen_r};

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			readdata <= '0;
		else if (read && busSt_r != IEV_READ) begin
			readdata <= '0;
			if (hit(address, `IEV_ADDR_CTRL))
				readdata[7:0] <= ctrl_r;
			else if (hit(address, `IEV_ADDR_STAT1))
				readdata[7:0] <= stat1;
			else if (hit(address, `IEV_ADDR_STAT2))
				readdata[7:0] <= stat2;
			else if (hit(address, `IEV_ADDR_DATA))
				readdata[7:0] <= data_r;
		end
	end

	// ---------------------------------------------------------------
	// outputs to core and serial engine
	// ---------------------------------------------------------------
	logic holdLow;
	assign holdLow = header_r | startSent_r | byteDone_r | addrMatch_r |
		addrEv_r;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irqReq          <= 1'b0;
			wakeReq         <= 1'b0;
			pinsOwned       <= 1'b0;
			ackOut          <= 1'b0;
			startReq        <= 1'b0;
			stopReq         <= 1'b0;
			releaseLines    <= 1'b0;
			sclHoldLow      <= 1'b0;
			genCallRecvOnly <= 1'b0;
			txData          <= `IEV_DATA_RESET;
		end else begin
			irqReq  <= event_r && ctrl_r[`IEV_CR_IRQEN] && !globalMask;
			// own events never leave halt
			wakeReq <= event_r && ctrl_r[`IEV_CR_IRQEN] && active;
			pinsOwned <= enable && active;
			ackOut    <= enable && active && ctrl_r[`IEV_CR_ACK];
			startReq  <= enable && ctrl_r[`IEV_CR_START];
			stopReq   <= enable && master_r && ctrl_r[`IEV_CR_STOP];
			releaseLines <= !enable || (!master_r &&
				ctrl_r[`IEV_CR_STOP] && byteDone_r);
			sclHoldLow <= enable && holdLow;
			genCallRecvOnly <= gcSeen_r;
			txData    <= data_r;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	match_clear_a: assert property (rdS1 && !pAddr && !pGc && active
		|=> !addrMatch_r) else $error("match flag not cleared");
	rx_clear_a: assert property (enable && active && byteDone_r && !dir_r
		&& seqRdDr && !pRx && !pTx |=> !byteDone_r)
		else $error("rx byte flag stuck");
	tx_hold_a: assert property (enable && byteDone_r && dir_r && !s1Read_r
		&& wrDr
		&& !byteRelease_r && !ackFail_r |=> byteDone_r)
		else $error("tx flag cleared without sequence");
	stop_clear_a: assert property (rdS2 && active && !pStop
		|=> !stopSeen_r) else $error("stop flag kept");
	disable_clr_a: assert property (!enable && active
		|=> ##1 !event_r && !byteDone_r && !startSent_r)
		else $error("flags survive disable");
	stop_keep_a: assert property (!enable && !wrCr && active
		&& ctrl_r[`IEV_CR_STOP] |=> ctrl_r[`IEV_CR_STOP])
		else $error("stop bit lost on disable");
	irq_gate_a: assert property (irqReq |-> $past(ctrl_r[`IEV_CR_IRQEN])
		&& !$past(globalMask)) else $error("ungated irq");
	ctl_zero_a: assert property (ctrl_r[7:6] == 2'b00)
		else $error("reserved control bits set");
	scl_hold_a: assert property (enable && startSent_r |=> sclHoldLow)
		else $error("clock not held");
	busy_set_a: assert property (enable && pStart && active |=> busy_r)
		else $error("busy not set");
	evt_src_a: assert property (event_r |-> $past(anySrc))
		else $error("event without source");

	rx_cov_c: cover property (pRx ##[1:20] seqRdDr);
	start_cov_c: cover property (pStSent ##[1:20] seqWrDr);
	stop_cov_c: cover property (pStop ##[1:20] rdS2);
	nack_cov_c: cover property (pNack ##[1:20] byteRelease_r);

endmodule

// ===== bench/iev_link_model.sv
// far-side model: serial engine events launched on the link clock
`timescale 1ns/10ps

module iev_link_model (
	input  wire logic        linkClk,
	input  wire logic [12:0] fireReq,
	input  wire logic [7:0]  rxByte,
	output logic      [12:0] evLines,
	output logic      [7:0]  rxData
);
	// ---------------------------------------------------------------
	// event launch
	// ---------------------------------------------------------------
	initial begin
		evLines = 13'h0000;
		rxData  = 8'h00;
	end

	// edges land on link edges, always 0.5 ns after a sys_clk rising edge
	always @(posedge linkClk) begin
		evLines <= fireReq;
		rxData  <= rxByte;
	end
endmodule

// ===== bench/testbench.sv
// self-checking bench of the event control logic
`timescale 1ns/10ps
`include "iev_consts.svh"
`define CHK(got, exp) begin nChecks++; if ((got) !== (exp)) begin fails++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end

module testbench;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic        sys_clk, reset_n, linkClk;
	logic [3:0]  address;
	logic        read, write, waitrequest;
	logic [31:0] writedata, readdata;
	logic        haltMode, globalMask, irqReq, wakeReq, slaveActive;
	logic [12:0] fireReq, evLines;
	logic [7:0]  rxByte, rxData, txData, rxv, txv, d;
	logic        pinsOwned, ackOut, startReq, stopReq;
	logic        releaseLines, sclHoldLow, genCallRecvOnly;
	int          fails, nChecks, cyc;
	integer      seed;

	iev_event_ctrl dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest),
		.haltMode(haltMode), .globalMask(globalMask),
		.irqReq(irqReq), .wakeReq(wakeReq),
		.evAddrMatch(evLines[0]), .evGenCall(evLines[1]),
		.evByteRx(evLines[2]), .evByteTx(evLines[3]),
		.evNack(evLines[4]), .evStart(evLines[5]), .evStop(evLines[6]),
		.evStartSent(evLines[7]), .evStopSent(evLines[8]),
		.evHeaderSent(evLines[9]), .evAddrSent(evLines[10]),
		.evArbLost(evLines[11]), .evBusError(evLines[12]),
		.slaveActive(slaveActive), .pinsOwned(pinsOwned),
		.ackOut(ackOut), .startReq(startReq), .stopReq(stopReq),
		.releaseLines(releaseLines), .sclHoldLow(sclHoldLow),
		.genCallRecvOnly(genCallRecvOnly), .txData(txData),
		.rxData(rxData)
	);

	iev_link_model partner (
		.linkClk(linkClk), .fireReq(fireReq), .rxByte(rxByte),
		.evLines(evLines), .rxData(rxData)
	);

	// ---------------------------------------------------------------
	// clocks and timeout
	// ---------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	initial begin
		linkClk = 1'b0;
		#13;
		forever #80 linkClk = ~linkClk;
	end

	// whole sequence needs well under 10000 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
	end

	// ---------------------------------------------------------------
	// bus and event tasks
	// ---------------------------------------------------------------
	task automatic report_and_stop();
		if (fails == 0 && nChecks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// request held until waitrequest is seen low at a rising edge
	task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		address   <= a;
		writedata <= {24'h000000, v};
		write     <= 1'b1;
		do @(posedge sys_clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask

	task automatic bus_rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		address <= a;
		read    <= 1'b1;
		do @(posedge sys_clk); while (waitrequest !== 1'b0);
		v = readdata[7:0];
		read <= 1'b0;
	endtask

	task automatic fire(input int idx);
		repeat (2) @(posedge sys_clk);
		fireReq[idx] <= 1'b1;
		repeat (100) @(posedge sys_clk);
		fireReq[idx] <= 1'b0;
		repeat (100) @(posedge sys_clk);
	endtask

	// act: 0 status read only, 1 data read, 2 data write, 3 control write
	task automatic ev_case(input int idx, input logic [7:0] e, input int act);
		rxv    = $random(seed);
		rxByte <= rxv;
		fire(idx);
		`CHK(irqReq, 1'b1)
		`CHK(sclHoldLow, 1'b1)
		bus_rd(`IEV_ADDR_STAT1, d);
		`CHK(d & 8'hcd, e | 8'h80)
		if (act == 1) begin
			bus_rd(`IEV_ADDR_DATA, d);
			`CHK(d, rxv)
		end else if (act == 2) begin
			txv = $random(seed);
			bus_wr(`IEV_ADDR_DATA, txv);
			repeat (2) @(posedge sys_clk);
			`CHK(txData, txv)
		end else if (act == 3) begin
			bus_wr(`IEV_ADDR_CTRL, 8'h35);
		end
		bus_rd(`IEV_ADDR_STAT1, d);
		`CHK(d & 8'hcd, 8'h00)
		`CHK(irqReq, 1'b0)
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		seed = 32'hec0a;
		{reset_n, read, write, haltMode, globalMask, slaveActive} = 6'h00;
		{address, writedata, fireReq, rxByte} = '0;
		{fails, nChecks, cyc} = '0;
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			bus_rd(i == 4 ? 4'h2 : 4'(i * 4), rxv);
			`CHK(rxv, 8'h00)
		end
		bus_wr(`IEV_ADDR_CTRL, 8'h35);
		bus_rd(`IEV_ADDR_CTRL, d);
		`CHK(d, 8'h20)
		txv = $random(seed);
		bus_wr(`IEV_ADDR_CTRL, {txv[7:6], 6'h35});
		bus_rd(`IEV_ADDR_CTRL, d);
		`CHK(d, 8'h35)
		`CHK(pinsOwned, 1'b1)
		`CHK(ackOut, 1'b1)
		ev_case(0, 8'h04, 0);
		ev_case(2, 8'h08, 1);
		ev_case(3, 8'h08, 2);
		bus_wr(`IEV_ADDR_CTRL, 8'h3d);
		repeat (3) @(posedge sys_clk);
		`CHK(startReq, 1'b1)
		ev_case(7, 8'h01, 2);
		bus_rd(`IEV_ADDR_CTRL, d);
		`CHK(d, 8'h35)
		ev_case(9, 8'h40, 2);
		ev_case(10, 8'h00, 3);
		fire(5);
		bus_rd(`IEV_ADDR_STAT1, d);
		`CHK(d[4], 1'b1)
		slaveActive <= 1'b1;
		fire(6);
		bus_rd(`IEV_ADDR_STAT1, d);
		`CHK(d & 8'h90, 8'h80)
		bus_rd(`IEV_ADDR_STAT2, d);
		`CHK(d & 8'h08, 8'h08)
		bus_rd(`IEV_ADDR_STAT2, d);
		`CHK(d & 8'h08, 8'h00)
		bus_rd(`IEV_ADDR_STAT1, d);
		`CHK(d[7], 1'b0)
		fire(1);
		`CHK(genCallRecvOnly, 1'b1)
		bus_rd(`IEV_ADDR_STAT2, d);
		`CHK(d[0], 1'b1)
		bus_rd(`IEV_ADDR_STAT1, d);
		`CHK(d & 8'hcd, 8'h84)
		fire(3);
		fire(4);
		bus_rd(`IEV_ADDR_STAT1, d);
		`CHK(d & 8'hcd, 8'h88)
		bus_rd(`IEV_ADDR_STAT2, d);
		`CHK(d[4], 1'b0)
		bus_wr(`IEV_ADDR_CTRL, 8'h37);
		repeat (2) @(posedge sys_clk);
		`CHK(releaseLines, 1'b1)
		bus_wr(`IEV_ADDR_CTRL, 8'h35);
		repeat (3) @(posedge sys_clk);
		bus_rd(`IEV_ADDR_STAT1, d);
		`CHK(d & 8'hcd, 8'h00)
		fire(6);
		bus_rd(`IEV_ADDR_STAT2, d);
		`CHK(d & 8'h19, 8'h00)
		slaveActive <= 1'b0;
		globalMask  <= 1'b1;
		fire(0);
		`CHK(irqReq, 1'b0)
		`CHK(wakeReq, 1'b1)
		globalMask <= 1'b0;
		repeat (3) @(posedge sys_clk);
		`CHK(irqReq, 1'b1)
		haltMode <= 1'b1;
		fire(3);
		`CHK(wakeReq, 1'b0)
		haltMode <= 1'b0;
		bus_rd(`IEV_ADDR_STAT1, d);
		`CHK(d & 8'h8c, 8'h84)
		fire(2);
		bus_wr(`IEV_ADDR_CTRL, 8'h02);
		bus_rd(`IEV_ADDR_CTRL, d);
		`CHK(d, 8'h02)
		bus_rd(`IEV_ADDR_STAT1, d);
		`CHK(d, 8'h00)
		`CHK({pinsOwned, ackOut, releaseLines}, 3'b001)
		report_and_stop();
	end
endmodule
